/* File: brd_decoder.sv */
/*
  First-level address decoder of the bus matrix with boot and remap
  selection at address zero, one decoder per master.
  Assumes AHB-lite masters on the same clock, slaves that answer
  in the data phase, and remap requests from logic on this clock.
*/
// Behaviour
// - Top four address bits pick sixteen banks
// - Banks one to eight go to external chip selects
// - Bank zero holds internal memories and the boot alias
// - Bank fifteen forwards to peripheral bridge
// - Unassigned areas answer with an abort
// - One decoder instance per master bus
// - Processor ports see one of three at zero
// - First fetch comes from memory at zero
// - Remap places first SRAM at zero
// - Without remap, strap picks ROM or external
// - Strap high maps embedded ROM at zero
// - Strap low maps chip select zero
// - Boot alias spans the first megabyte
// - Other memories stay at fixed bases
// - External boot defaults static controller configuration
// - Each chip select owns one bank window
// - Chip selects one, three, four, five retargetable
// - ROM and SRAMs answer in one cycle
// - Meaningless master paths are blocked
`include "brd_params.svh"

module brd_decoder
    import brd_pkg::*;
#(
    parameter int NUM_MASTERS = `BRD_NUM_MASTERS
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic boot_source_pin,
    input wire logic remap_set,
    input wire logic remap_clr,
    input wire logic cs1_sdram,
    input wire logic cs3_nand,
    input wire logic cs45_cf,
    input wire logic [NUM_MASTERS-1:0][31:0] m_haddr,
    input wire logic [NUM_MASTERS-1:0][1:0] m_htrans,
    input wire logic [NUM_MASTERS-1:0] m_hready_in,
    output brd_slave_e [NUM_MASTERS-1:0] m_slave,
    output logic [NUM_MASTERS-1:0][2:0] m_cs_idx,
    output brd_ebi_e [NUM_MASTERS-1:0] m_ebi_ctrl,
    output logic [NUM_MASTERS-1:0] m_hresp,
    output logic [NUM_MASTERS-1:0] m_hready_out,
    output logic remap_active,
    output logic boot_from_rom,
    output logic strap_done,
    output logic smc_boot_byte_sel,
    output logic smc_boot_bus16,
    output logic smc_boot_cs_strobe
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic remap;
        logic ext_boot;
        brd_err_e [NUM_MASTERS-1:0] err;
    } brd_dec_s;

    brd_dec_s q, d;

    logic boot_rom;
    logic [NUM_MASTERS-1:0] active;
    logic [NUM_MASTERS-1:0] abort_now;

    // ----------------------------------------
    // Boot strap
    // ----------------------------------------
    brd_boot_strap u_strap (
        .clk(clk),
        .sys_rst(sys_rst),
        .boot_source_pin(boot_source_pin),
        .boot_rom(boot_rom),
        .strap_done(strap_done)
    );

    // ----------------------------------------
    // Per-master decoders
    // ----------------------------------------
    // Each master keeps its own decoder so access rights may differ per port
    for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_dec
        assign active[m] = m_htrans[m][1];
        brd_master_decode #(
            .MASTER_ID(m)
        ) u_dec (
            .addr(m_haddr[m]),
            .active(active[m]),
            .remap(q.remap),
            .boot_rom(boot_rom),
            .cs1_sdram(cs1_sdram),
            .cs3_nand(cs3_nand),
            .cs45_cf(cs45_cf),
            .slave(m_slave[m]),
            .cs_idx(m_cs_idx[m]),
            .ebi_ctrl(m_ebi_ctrl[m])
        );
        // Internal memories are zero-wait, so only aborts stall the master
        assign abort_now[m] = active[m] && m_hready_in[m] && (m_slave[m] == SLV_NONE);
        assign m_hresp[m] = (q.err[m] != ERR_IDLE);
        assign m_hready_out[m] = (q.err[m] != ERR_FIRST);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        // Set wins over clear so a late software request is never lost
        if (remap_set) begin
            d.remap = 1'b1;
        end else if (remap_clr) begin
            d.remap = 1'b0;
        end
        d.ext_boot = strap_done && !boot_rom;
        for (int i = 0; i < NUM_MASTERS; i++) begin
            case (q.err[i])
                ERR_IDLE: begin
                    if (abort_now[i]) begin
                        d.err[i] = ERR_FIRST;
                    end
                end
                ERR_FIRST: begin
                    d.err[i] = ERR_SECOND;
                end
                ERR_SECOND: begin
                    // A new unmapped address may follow back to back
                    d.err[i] = abort_now[i] ? ERR_FIRST : ERR_IDLE;
                end
                default: begin
                    d.err[i] = ERR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q.remap <= 1'b0;
            q.ext_boot <= 1'b0;
            q.err <= '{default: ERR_IDLE};
        end else begin
            q <= d;
        end
    end

    assign remap_active = q.remap;
    assign boot_from_rom = boot_rom;
    assign smc_boot_byte_sel = q.ext_boot;
    assign smc_boot_bus16 = q.ext_boot;
    assign smc_boot_cs_strobe = q.ext_boot;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_remap_cleared: assert property (
        @(posedge clk) $past(sys_rst) && !sys_rst |-> !remap_active)
        else $error("remap not cleared by reset");

    chk_remap_takes: assert property (
        @(posedge clk) disable iff (sys_rst)
        remap_set |=> remap_active)
        else $error("remap request ignored");

    chk_strap_timing: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> !strap_done ##3 strap_done)
        else $error("strap not captured three cycles after reset");

    chk_strap_stable: assert property (
        @(posedge clk) disable iff (sys_rst)
        strap_done && $past(strap_done) |-> $stable(boot_from_rom))
        else $error("strap value changed after capture");

    chk_ext_boot_cfg: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(strap_done) |-> (smc_boot_bus16 == !boot_from_rom) && (smc_boot_byte_sel == smc_boot_cs_strobe))
        else $error("external boot defaults wrong");

    for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_chk
        chk_bank_peri: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && m_haddr[m][31:28] == `BRD_BANK_PERIPH
            |-> m_slave[m] == ((m < `BRD_ROM_MASTERS) ? SLV_PERIPH : SLV_NONE))
            else $error("peripheral bank misrouted");

        chk_ebi_cs: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && m_haddr[m][31:28] >= `BRD_BANK_EBI_FIRST && m_haddr[m][31:28] <= `BRD_BANK_EBI_LAST
            |-> m_slave[m] == SLV_EBI && m_cs_idx[m] == 3'(m_haddr[m][31:28] - 4'h1))
            else $error("external bank chip select wrong");

        chk_unused_bank: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && m_haddr[m][31:28] > `BRD_BANK_EBI_LAST && m_haddr[m][31:28] < `BRD_BANK_PERIPH
            |-> m_slave[m] == SLV_NONE)
            else $error("unused bank not aborted");

        chk_sram1_fixed: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && (m_haddr[m] & `BRD_SRAM_MASK) == `BRD_SRAM1_BASE |-> m_slave[m] == SLV_SRAM1)
            else $error("second SRAM moved");

        chk_abort_resp: assert property (
            @(posedge clk) disable iff (sys_rst)
            abort_now[m] && q.err[m] == ERR_IDLE
            |=> (m_hresp[m] && !m_hready_out[m]) ##1 (m_hresp[m] && m_hready_out[m]))
            else $error("abort response not two cycles");

        chk_cs1_target: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && m_haddr[m][31:28] == 4'h2
            |-> m_ebi_ctrl[m] == (cs1_sdram ? EBI_SDRAM : EBI_SMC))
            else $error("chip select one target wrong");

        if (m < `BRD_CPU_MASTERS) begin : g_cpu
            chk_zero_remap: assert property (
                @(posedge clk) disable iff (sys_rst)
                active[m] && remap_active && m_haddr[m] <= `BRD_BOOT_LIMIT |-> m_slave[m] == SLV_FIRST_INTERNAL_SRAM)
                else $error("remap did not place SRAM at zero");

            chk_zero_rom: assert property (
                @(posedge clk) disable iff (sys_rst)
                active[m] && !remap_active && boot_from_rom && m_haddr[m] <= `BRD_BOOT_LIMIT
                |-> m_slave[m] == SLV_ROM)
                else $error("ROM boot alias missing");

            chk_zero_ext: assert property (
                @(posedge clk) disable iff (sys_rst)
                active[m] && !remap_active && !boot_from_rom && m_haddr[m] <= `BRD_BOOT_LIMIT
                |-> m_slave[m] == SLV_EBI && m_cs_idx[m] == 3'h0)
                else $error("external boot alias missing");
        end else begin : g_dma
            // Only the processor ports own the boot alias
            chk_alias_blocked: assert property (
                @(posedge clk) disable iff (sys_rst)
                active[m] && m_haddr[m] <= `BRD_BOOT_LIMIT |-> m_slave[m] == SLV_NONE)
                else $error("boot alias reached by non-processor master");
        end

        // ----------------------------------------
        // Per-master decode and response checks
        // ----------------------------------------
        chk_idle_none: assert property (
            @(posedge clk) disable iff (sys_rst)
            !active[m] |-> m_slave[m] == SLV_NONE)
            else $error("idle master decodes a slave");

        chk_cs_quiet: assert property (
            @(posedge clk) disable iff (sys_rst)
            m_slave[m] != SLV_EBI |-> m_cs_idx[m] == 3'h0 && m_ebi_ctrl[m] == EBI_SMC)
            else $error("chip select outputs set off the external bus");

        chk_first_internal_sram_fixed: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && (m_haddr[m] & `BRD_SRAM_MASK) == `BRD_FIRST_INTERNAL_SRAM_BASE |-> m_slave[m] == SLV_FIRST_INTERNAL_SRAM)
            else $error("first SRAM moved");

        chk_rom_fixed: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && (m_haddr[m] & `BRD_ROM_MASK) == `BRD_ROM_BASE
            |-> m_slave[m] == ((m < `BRD_ROM_MASTERS) ? SLV_ROM : SLV_NONE))
            else $error("fixed ROM window misrouted");

        chk_uhp_path: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && (m_haddr[m] & `BRD_UHP_MASK) == `BRD_UHP_BASE
            |-> m_slave[m] == ((m < `BRD_CPU_MASTERS) ? SLV_UHP : SLV_NONE))
            else $error("host interface path wrong");

        chk_bank_zero: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && m_haddr[m][31:28] == `BRD_BANK_INT
            |-> m_slave[m] != SLV_PERIPH && (m_slave[m] != SLV_EBI || m_haddr[m] <= `BRD_BOOT_LIMIT))
            else $error("bank zero left the internal memories");

        chk_cs3_target: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && m_haddr[m][31:28] == 4'h4
            |-> m_ebi_ctrl[m] == (cs3_nand ? EBI_NAND : EBI_SMC))
            else $error("chip select three target wrong");

        chk_cf_target: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && (m_haddr[m][31:28] == 4'h5 || m_haddr[m][31:28] == 4'h6)
            |-> m_ebi_ctrl[m] == (cs45_cf ? EBI_CF : EBI_SMC))
            else $error("chip select four or five target wrong");

        chk_err_second: assert property (
            @(posedge clk) disable iff (sys_rst)
            m_hresp[m] && !m_hready_out[m] |=> m_hresp[m] && m_hready_out[m])
            else $error("error response did not end with ready");

        chk_err_cause: assert property (
            @(posedge clk) disable iff (sys_rst)
            m_hresp[m] && !m_hready_out[m] |-> $past(abort_now[m]))
            else $error("error response without an unmapped access");

        chk_stall_only_err: assert property (
            @(posedge clk) disable iff (sys_rst)
            !m_hready_out[m] |-> m_hresp[m])
            else $error("wait state without an error");

        // Mapped slaves are zero-wait, so the decoder must never stall them
        chk_mapped_no_wait: assert property (
            @(posedge clk) disable iff (sys_rst)
            active[m] && m_hready_in[m] && m_slave[m] != SLV_NONE |=> m_hready_out[m])
            else $error("mapped access stalled");
    end

    // ----------------------------------------
    // Reset, strap and remap checks
    // ----------------------------------------
    chk_strap_in_reset: assert property (
        @(posedge clk)
        sys_rst |=> !strap_done && boot_from_rom)
        else $error("strap state not reset");

    chk_ext_cfg_reset: assert property (
        @(posedge clk)
        sys_rst |=> !smc_boot_bus16 && !smc_boot_byte_sel && !smc_boot_cs_strobe)
        else $error("external boot defaults not reset");

    chk_strap_kept: assert property (
        @(posedge clk) disable iff (sys_rst)
        strap_done |=> strap_done)
        else $error("strap capture lost before reset");

    chk_remap_clears: assert property (
        @(posedge clk) disable iff (sys_rst)
        remap_clr && !remap_set |=> !remap_active)
        else $error("remap clear ignored");

    chk_remap_holds: assert property (
        @(posedge clk) disable iff (sys_rst)
        !remap_set && !remap_clr |=> $stable(remap_active))
        else $error("remap changed without a request");

endmodule

/* File: brd_params.svh */
/*
  Address map constants for the boot and remap address decoder.
  Assumes a 32-bit AHB address and a single matrix clock.
*/
`ifndef BRD_PARAMS_SVH
`define BRD_PARAMS_SVH

// ----------------------------------------
// Bank split
// ----------------------------------------
`define BRD_NUM_MASTERS 6
`define BRD_BANK_MSB 31
`define BRD_BANK_LSB 28
`define BRD_BANK_INT 4'h0
`define BRD_BANK_EBI_FIRST 4'h1
`define BRD_BANK_EBI_LAST 4'h8
`define BRD_BANK_PERIPH 4'hF

// ----------------------------------------
// Internal memory windows in bank zero
// ----------------------------------------
`define BRD_BOOT_LIMIT 32'h000F_FFFF
`define BRD_ROM_BASE 32'h0010_0000
`define BRD_ROM_MASK 32'hFFFF_8000
`define BRD_FIRST_INTERNAL_SRAM_BASE 32'h0020_0000
`define BRD_SRAM1_BASE 32'h0030_0000
`define BRD_SRAM_MASK 32'hFFFF_F000
`define BRD_UHP_BASE 32'h0050_0000
`define BRD_UHP_MASK 32'hFFFF_C000

// ----------------------------------------
// Chip selects with special controllers
// ----------------------------------------
`define BRD_CS_SDRAM 3'h1
`define BRD_CS_NAND 3'h3
`define BRD_CS_CF0 3'h4
`define BRD_CS_CF1 3'h5

// ----------------------------------------
// Strap timing and master classes
// ----------------------------------------
`define BRD_STRAP_SYNC_CYC 2'h2
`define BRD_CPU_MASTERS 2
`define BRD_ROM_MASTERS 4

`endif

/* File: brd_pkg.sv */
/*
  Types and the window test shared by the decoder modules.
  Assumes brd_params.svh is on the include path.
*/
`include "brd_params.svh"

package brd_pkg;

    typedef enum logic [2:0] {SLV_NONE, SLV_ROM, SLV_FIRST_INTERNAL_SRAM, SLV_SRAM1, SLV_UHP, SLV_EBI, SLV_PERIPH} brd_slave_e;
    typedef enum logic [1:0] {EBI_SMC, EBI_SDRAM, EBI_NAND, EBI_CF} brd_ebi_e;
    typedef enum logic [1:0] {ERR_IDLE, ERR_FIRST, ERR_SECOND} brd_err_e;

    function automatic logic brd_hit(input logic [31:0] a, input logic [31:0] base, input logic [31:0] mask);
        return (a & mask) == base;
    endfunction

endpackage

/* File: brd_boot_strap.sv */
/*
  Boot source strap capture: synchronises the boot source pin and
  latches it once after reset release. Assumes the pin is static
  around reset release.
*/
`include "brd_params.svh"

module brd_boot_strap
    import brd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic boot_source_pin,
    output logic boot_rom,
    output logic strap_done
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic [1:0] cnt;
        logic done;
        logic rom;
    } brd_strap_s;

    brd_strap_s q, d;

    always_comb begin
        d = q;
        d.meta = boot_source_pin;
        d.sync = q.meta;
        if (!q.done) begin
            // Wait for the synchroniser to fill before trusting the level
            if (q.cnt == `BRD_STRAP_SYNC_CYC) begin
                d.done = 1'b1;
                d.rom = q.sync;
            end else begin
                d.cnt = q.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '{meta: 1'b0, sync: 1'b0, cnt: 2'h0, done: 1'b0, rom: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign boot_rom = q.rom;
    assign strap_done = q.done;

endmodule

/* File: brd_master_decode.sv */
/*
  Address decoder for one bus master. Purely combinational.
  Assumes the address is valid whenever active is high.
*/
`include "brd_params.svh"

module brd_master_decode
    import brd_pkg::*;
#(
    parameter int MASTER_ID = 0
)(
    input wire logic [31:0] addr,
    input wire logic active,
    input wire logic remap,
    input wire logic boot_rom,
    input wire logic cs1_sdram,
    input wire logic cs3_nand,
    input wire logic cs45_cf,
    output brd_slave_e slave,
    output logic [2:0] cs_idx,
    output brd_ebi_e ebi_ctrl
);

    localparam bit CPU = (MASTER_ID < `BRD_CPU_MASTERS);
    localparam bit SYS_OK = (MASTER_ID < `BRD_ROM_MASTERS);

    logic [3:0] bank;

    always_comb begin
        bank = addr[`BRD_BANK_MSB:`BRD_BANK_LSB];
        slave = SLV_NONE;
        cs_idx = 3'h0;
        ebi_ctrl = EBI_SMC;
        if (active) begin
            if (bank == `BRD_BANK_INT) begin
                // Boot alias only exists for the processor ports
                if (addr <= `BRD_BOOT_LIMIT) begin
                    if (CPU) begin
                        if (remap) begin
                            slave = SLV_FIRST_INTERNAL_SRAM;
                        end else if (boot_rom) begin
                            slave = SLV_ROM;
                        end else begin
                            slave = SLV_EBI;
                        end
                    end
                end else if (brd_hit(addr, `BRD_ROM_BASE, `BRD_ROM_MASK) && SYS_OK) begin
                    slave = SLV_ROM;
                end else if (brd_hit(addr, `BRD_FIRST_INTERNAL_SRAM_BASE, `BRD_SRAM_MASK)) begin
                    slave = SLV_FIRST_INTERNAL_SRAM;
                end else if (brd_hit(addr, `BRD_SRAM1_BASE, `BRD_SRAM_MASK)) begin
                    slave = SLV_SRAM1;
                end else if (brd_hit(addr, `BRD_UHP_BASE, `BRD_UHP_MASK) && CPU) begin
                    slave = SLV_UHP;
                end
            end else if (bank >= `BRD_BANK_EBI_FIRST && bank <= `BRD_BANK_EBI_LAST) begin
                slave = SLV_EBI;
                cs_idx = 3'(bank - `BRD_BANK_EBI_FIRST);
            end else if (bank == `BRD_BANK_PERIPH && SYS_OK) begin
                slave = SLV_PERIPH;
            end
        end
        if (slave == SLV_EBI) begin
            if (cs_idx == `BRD_CS_SDRAM && cs1_sdram) begin
                ebi_ctrl = EBI_SDRAM;
            end else if (cs_idx == `BRD_CS_NAND && cs3_nand) begin
                ebi_ctrl = EBI_NAND;
            end else if ((cs_idx == `BRD_CS_CF0 || cs_idx == `BRD_CS_CF1) && cs45_cf) begin
                ebi_ctrl = EBI_CF;
            end
        end
    end

endmodule

/* File: brd_bus_master_model.sv */
/*
  Behavioural model of the bus masters facing the decoder, one AHB
  address phase per master. Assumes the bench hands it requests on
  the matrix clock and that HREADY on each bus is the decoder's.
*/
module brd_bus_master_model
    import brd_pkg::*;
#(
    parameter int NUM_MASTERS = 6
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [NUM_MASTERS-1:0][31:0] req_addr,
    input wire logic [NUM_MASTERS-1:0] req_act,
    input wire logic [NUM_MASTERS-1:0] m_hready_out,
    output logic [NUM_MASTERS-1:0][31:0] m_haddr,
    output logic [NUM_MASTERS-1:0][1:0] m_htrans,
    output logic [NUM_MASTERS-1:0] m_hready_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Only the decoder answers on these buses, so its ready is the bus ready
    assign m_hready_in = m_hready_out;

    always_ff @(posedge clk) begin
        for (int m = 0; m < NUM_MASTERS; m++) begin
            if (sys_rst) begin
                m_htrans[m] <= 2'h0;
                m_haddr[m] <= 32'h0000_0000;
            end else if (m_hready_out[m]) begin
                m_htrans[m] <= req_act[m] ? 2'h2 : 2'h0;
                // Idle address keeps moving so a stale value never decodes by luck
                m_haddr[m] <= req_act[m] ? req_addr[m] : ~m_haddr[m];
            end
        end
    end
endmodule

/* File: tb_top.sv */
/*
  Self-checking bench for the boot and remap address decoder.
  Assumes the design package and the master model are compiled first.
*/
module tb_top
    import brd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int NM = 6;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic boot_source_pin = 1'b1;
    logic remap_set = 1'b0;
    logic remap_clr = 1'b0;
    logic cs1_sdram = 1'b0;
    logic cs3_nand = 1'b0;
    logic cs45_cf = 1'b0;
    logic [NM-1:0][31:0] req_addr = '0;
    logic [NM-1:0] req_act = '0;
    logic [NM-1:0][31:0] m_haddr;
    logic [NM-1:0][1:0] m_htrans;
    logic [NM-1:0] m_hready_in;
    brd_slave_e [NM-1:0] m_slave;
    logic [NM-1:0][2:0] m_cs_idx;
    brd_ebi_e [NM-1:0] m_ebi_ctrl;
    logic [NM-1:0] m_hresp;
    logic [NM-1:0] m_hready_out;
    logic remap_active, boot_from_rom, strap_done;
    logic smc_boot_byte_sel, smc_boot_bus16, smc_boot_cs_strobe;
    int error_cnt = 0;
    int num_checks = 0;

    always #5 clk = ~clk;

    brd_decoder #(.NUM_MASTERS(NM)) brd_decoder_inst (.clk(clk), .sys_rst(sys_rst),
        .boot_source_pin(boot_source_pin), .remap_set(remap_set), .remap_clr(remap_clr),
        .cs1_sdram(cs1_sdram), .cs3_nand(cs3_nand), .cs45_cf(cs45_cf), .m_haddr(m_haddr),
        .m_htrans(m_htrans), .m_hready_in(m_hready_in), .m_slave(m_slave), .m_cs_idx(m_cs_idx),
        .m_ebi_ctrl(m_ebi_ctrl), .m_hresp(m_hresp), .m_hready_out(m_hready_out),
        .remap_active(remap_active), .boot_from_rom(boot_from_rom), .strap_done(strap_done),
        .smc_boot_byte_sel(smc_boot_byte_sel), .smc_boot_bus16(smc_boot_bus16),
        .smc_boot_cs_strobe(smc_boot_cs_strobe));

    brd_bus_master_model #(.NUM_MASTERS(NM)) brd_bus_master_model_inst (.clk(clk), .sys_rst(sys_rst),
        .req_addr(req_addr), .req_act(req_act), .m_hready_out(m_hready_out), .m_haddr(m_haddr),
        .m_htrans(m_htrans), .m_hready_in(m_hready_in));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic fail(input string msg);
        error_cnt++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic results();
        $display("error_cnt=%0d num_checks=%0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Three idle edges first so an earlier abort has fully run out
    task automatic dec(input int m, input logic [31:0] a, input brd_slave_e s, input logic [2:0] cs);
        repeat (3) @(posedge clk);
        req_addr[m] <= a;
        req_act[m] <= 1'b1;
        @(posedge clk);
        req_act[m] <= 1'b0;
        #1;
        num_checks++;
        if (m_slave[m] !== s || m_cs_idx[m] !== cs) fail($sformatf("decode m%0d addr %h", m, a));
    endtask

    function automatic brd_ebi_e exp_ebi(input int cs, input bit en);
        if (!en) return EBI_SMC;
        case (cs)
            1: return EBI_SDRAM;
            3: return EBI_NAND;
            4, 5: return EBI_CF;
            default: return EBI_SMC;
        endcase
    endfunction

    task automatic do_reset(input logic pin);
        int n;
        @(posedge clk);
        boot_source_pin <= pin;
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        n = 0;
        #1;
        while (strap_done !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        num_checks++;
        if (n > 5 || boot_from_rom !== pin || remap_active !== 1'b0) fail("strap capture after reset");
        repeat (2) @(posedge clk);
        #1;
        num_checks++;
        if ({smc_boot_byte_sel, smc_boot_bus16, smc_boot_cs_strobe} !== {3{~pin}}) fail("static boot defaults");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_internal();
        dec(0, 32'h0000_0000, SLV_ROM, 3'h0);
        dec(1, 32'h000F_FFFC, SLV_ROM, 3'h0);
        dec(1, 32'h0010_0004, SLV_ROM, 3'h0);
        dec(2, 32'h0000_0000, SLV_NONE, 3'h0);
        dec(0, 32'h0030_0010, SLV_SRAM1, 3'h0);
        dec(0, 32'h0050_0000, SLV_UHP, 3'h0);
        dec(2, 32'h0050_0000, SLV_NONE, 3'h0);
        dec(0, 32'h0040_0000, SLV_NONE, 3'h0);
        dec(4, 32'h0010_0000, SLV_NONE, 3'h0);
        dec(4, 32'h0020_0000, SLV_FIRST_INTERNAL_SRAM, 3'h0);
        dec(5, 32'hF000_0000, SLV_NONE, 3'h0);
        num_checks++;
        if (m_slave[0] !== SLV_NONE) fail("idle master decodes a slave");
    endtask

    task automatic t_banks();
        for (int b = 1; b < 16; b++) begin
            if (b <= 8)
                dec(2, {b[3:0], 28'h123_4560}, SLV_EBI, 3'(b - 1));
            else if (b < 15)
                dec(2, {b[3:0], 28'h123_4560}, SLV_NONE, 3'h0);
            else
                dec(2, {b[3:0], 28'h123_4560}, SLV_PERIPH, 3'h0);
        end
    endtask

    task automatic t_ebi();
        for (int en = 0; en < 2; en++) begin
            @(posedge clk);
            cs1_sdram <= en[0];
            cs3_nand <= en[0];
            cs45_cf <= en[0];
            for (int b = 2; b <= 7; b++) begin
                dec(1, {b[3:0], 28'h000_0000}, SLV_EBI, 3'(b - 1));
                num_checks++;
                if (m_ebi_ctrl[1] !== exp_ebi(b - 1, en[0])) fail($sformatf("controller for bank %0d", b));
            end
        end
    endtask

    task automatic t_remap();
        @(posedge clk);
        remap_set <= 1'b1;
        remap_clr <= 1'b1;
        @(posedge clk);
        remap_set <= 1'b0;
        remap_clr <= 1'b0;
        #1;
        num_checks++;
        if (remap_active !== 1'b1) fail("remap not set");
        dec(0, 32'h0000_0040, SLV_FIRST_INTERNAL_SRAM, 3'h0);
        dec(1, 32'h0020_0000, SLV_FIRST_INTERNAL_SRAM, 3'h0);
        dec(1, 32'h0010_0000, SLV_ROM, 3'h0);
        @(posedge clk);
        remap_clr <= 1'b1;
        @(posedge clk);
        remap_clr <= 1'b0;
        dec(0, 32'h0000_0000, SLV_ROM, 3'h0);
    endtask

    task automatic t_abort();
        dec(3, 32'h9000_0000, SLV_NONE, 3'h0);
        @(posedge clk);
        #1;
        num_checks++;
        if (m_hresp[3] !== 1'b1 || m_hready_out[3] !== 1'b0) fail("first error cycle");
        @(posedge clk);
        #1;
        num_checks++;
        if (m_hresp[3] !== 1'b1 || m_hready_out[3] !== 1'b1) fail("second error cycle");
        @(posedge clk);
        #1;
        num_checks++;
        if (m_hresp[3] !== 1'b0 || m_hready_out[3] !== 1'b1) fail("error response lingers");
    endtask

    task automatic t_ext_boot();
        do_reset(1'b0);
        dec(0, 32'h0000_0000, SLV_EBI, 3'h0);
        @(posedge clk);
        boot_source_pin <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        num_checks++;
        if (boot_from_rom !== 1'b0) fail("strap changed after capture");
        dec(1, 32'h0008_0000, SLV_EBI, 3'h0);
    endtask

    initial begin
        do_reset(1'b1);
        t_internal();
        t_banks();
        t_ebi();
        t_remap();
        t_abort();
        t_ext_boot();
        results();
    end

    // A full pass needs well under 2000 cycles
    initial begin
        #100000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end
endmodule
